// >>> design/cmt_pkg.sv
package cmt_pkg;

	// ************************************************************
	// Bus and channel geometry
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int NCH = 4;
	localparam int NPIN = 8;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_CLEAR = 12'h004;
	localparam logic [11:0] OFS_IEN = 12'h008;
	localparam logic [11:0] OFS_CTRL = 12'h00C;
	localparam logic [11:0] OFS_TC = 12'h010;
	localparam logic [11:0] OFS_PR = 12'h014;
	localparam logic [11:0] OFS_PC = 12'h018;
	localparam logic [11:0] OFS_MCR = 12'h01C;
	localparam logic [11:0] OFS_MR0 = 12'h020;
	localparam logic [11:0] OFS_MR_END = 12'h030;
	localparam logic [11:0] OFS_CCR = 12'h030;
	localparam logic [11:0] OFS_CR0 = 12'h034;
	localparam logic [11:0] OFS_CR_END = 12'h044;
	localparam logic [11:0] OFS_EMR = 12'h044;
	localparam logic [11:0] OFS_CTCR = 12'h048;
	localparam logic [11:0] OFS_ROUTE = 12'h04C;
	localparam logic [11:0] OFS_MOUT_EN = 12'h050;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_EN = 0;
	localparam int CTRL_RST = 1;
	localparam int MCR_INT = 0;
	localparam int MCR_RST = 1;
	localparam int MCR_STOP = 2;
	localparam int MCR_STRIDE = 3;
	localparam int CCR_RISE = 0;
	localparam int CCR_FALL = 1;
	localparam int CCR_INT = 2;
	localparam int CCR_STRIDE = 3;
	localparam int EMR_ACT_LSB = 4;
	localparam int CTCR_MODE_LSB = 0;
	localparam int CTCR_SEL_LSB = 2;
	localparam int ROUTE_PRI = 0;
	localparam int ROUTE_ALT = 1;
	localparam int ROUTE_AND = 2;
	localparam int ROUTE_STRIDE = 3;
	localparam int ST_CAP_LSB = 4;

	// ************************************************************
	// Encodings
	// ************************************************************
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_RISE = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_BOTH = 2'h3;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	// ************************************************************
	// Values after reset
	// ************************************************************
	localparam logic [11:0] ROUTE_RST = 12'h249;
	localparam logic [7:0] MOUT_EN_RST = 8'h0F;
	localparam logic [31:0] WORD_RST = 32'h0;

endpackage

// >>> design/cmt_edge_if.sv
`timescale 1ns/1ps
interface cmt_edge_if;
	logic [11:0] route_cfg;
	logic [3:0] level;
	logic [3:0] rise;
	logic [3:0] fall;
	modport src (input route_cfg, output level, output rise, output fall);
	modport sink (output route_cfg, input level, input rise, input fall);
endinterface

// >>> design/cmt_pin_route.sv
`timescale 1ns/1ps
module cmt_pin_route (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] capture_input_pin,
	cmt_edge_if.src edge_bus
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [3:0] prev;
	} cmt_route_state_t;

	cmt_route_state_t st;
	cmt_route_state_t next_st;
	logic [3:0] comb_level;

	// ************************************************************
	// Pin combining per capture channel
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < cmt_pkg::NCH; g++)
		begin : gen_ch
			logic en_p;
			logic en_a;
			logic pin_p;
			logic pin_a;
			assign en_p = edge_bus.route_cfg[g * cmt_pkg::ROUTE_STRIDE
				+ cmt_pkg::ROUTE_PRI];
			assign en_a = edge_bus.route_cfg[g * cmt_pkg::ROUTE_STRIDE
				+ cmt_pkg::ROUTE_ALT];
			assign pin_p = capture_input_pin[g];
			assign pin_a = capture_input_pin[g + cmt_pkg::NCH];
			// And mode ignores disabled pins; no pin at all reads low
			assign comb_level[g] = edge_bus.route_cfg[g *
				cmt_pkg::ROUTE_STRIDE + cmt_pkg::ROUTE_AND]
				? ((pin_p | ~en_p) & (pin_a | ~en_a) & (en_p | en_a))
				: ((pin_p & en_p) | (pin_a & en_a));
		end
	endgenerate

	always_comb
	begin
		next_st = st;
		next_st.prev = comb_level;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign edge_bus.level = comb_level;
	assign edge_bus.rise = comb_level & ~st.prev;
	assign edge_bus.fall = ~comb_level & st.prev;

endmodule

// >>> design/cmt_timer.sv
`timescale 1ns/1ps
// Operation
// - A 32-bit counter advances once each time a 32-bit prescaler wraps.
// - Software picks peripheral clock cycles or external edges as source.
// - In counter mode exactly one capture channel is the count clock.
// - Channels not used as count clock still capture and raise events.
// - Four capture channels load the count on an input edge, optional irq.
// - Four match registers may interrupt, stop or reset the counter.
// - Four match outputs go low, go high, toggle or hold on a match.
// - Two pins combine into one capture by OR or AND; outputs broadcast.
// - All match and capture flags merge onto one interrupt line.
module cmt_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] capture_input_pin,
	output logic [7:0] match_pin,
	output logic irq
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [1:0] ctrl;
		logic [31:0] tc;
		logic [31:0] pr;
		logic [31:0] pc;
		logic [11:0] mcr;
		logic [3:0][31:0] mr;
		logic [11:0] ccr;
		logic [3:0][31:0] cr;
		logic [11:0] emr;
		logic [3:0] ctcr;
		logic [11:0] route;
		logic [7:0] mout_en;
		logic [7:0] ien;
		logic [7:0] status;
		logic irq;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [7:0] match_pin;
	} cmt_state_t;

	cmt_state_t st;
	cmt_state_t next_st;

	cmt_edge_if edge_bus ();

	logic [3:0] match_hit;
	logic [3:0] cap_hit;
	logic [3:0] cap_flag;
	logic [1:0] mode;
	logic [1:0] sel;
	logic counting;
	logic src_tick;

	// ************************************************************
	// Capture pin routing and edge detection
	// ************************************************************
	cmt_pin_route u_route (
		.pclk(pclk),
		.presetn(presetn),
		.capture_input_pin(capture_input_pin),
		.edge_bus(edge_bus)
	);

	assign edge_bus.route_cfg = st.route;

	// ************************************************************
	// Count source
	// ************************************************************
	assign mode = st.ctcr[cmt_pkg::CTCR_MODE_LSB +: 2];
	assign sel = st.ctcr[cmt_pkg::CTCR_SEL_LSB +: 2];
	assign counting = (mode != cmt_pkg::MODE_TIMER);

	// Edges are only seen at the clock; faster sources are the user's duty
	always_comb
	begin
		src_tick = 1'b0;
		case (mode)
			cmt_pkg::MODE_TIMER: src_tick = 1'b1;
			cmt_pkg::MODE_RISE: src_tick = edge_bus.rise[sel];
			cmt_pkg::MODE_FALL: src_tick = edge_bus.fall[sel];
			cmt_pkg::MODE_BOTH:
				src_tick = edge_bus.rise[sel] | edge_bus.fall[sel];
			default: src_tick = 1'b0;
		endcase
	end

	// ************************************************************
	// Per channel match and capture detection
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < cmt_pkg::NCH; g++)
		begin : gen_ch
			logic edge_sel;
			logic is_clock;
			assign match_hit[g] = (st.tc == st.mr[g]);
			assign edge_sel = (st.ccr[g * cmt_pkg::CCR_STRIDE
				+ cmt_pkg::CCR_RISE] & edge_bus.rise[g])
				| (st.ccr[g * cmt_pkg::CCR_STRIDE + cmt_pkg::CCR_FALL]
				& edge_bus.fall[g]);
			// The count clock channel must not also snapshot itself
			assign is_clock = counting && (sel == g);
			assign cap_hit[g] = edge_sel & ~is_clock;
			assign cap_flag[g] = cap_hit[g] & st.ccr[g *
				cmt_pkg::CCR_STRIDE + cmt_pkg::CCR_INT];
		end
	endgenerate

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		logic run;
		logic step;
		logic tick;
		logic acc;
		logic wr;
		logic hit;
		logic [31:0] rdata;
		logic [7:0] set_bits;
		logic [7:0] clr_bits;
		logic [1:0] act;
		logic [11:0] mofs;
		logic [11:0] cofs;
		next_st = st;
		run = 1'b0;
		step = 1'b0;
		tick = 1'b0;
		acc = psel & penable & ~st.pready;
		wr = psel & penable & st.pready & pwrite;
		hit = 1'b1;
		rdata = '0;
		set_bits = '0;
		clr_bits = '0;
		act = cmt_pkg::ACT_NONE;
		mofs = paddr - cmt_pkg::OFS_MR0;
		cofs = paddr - cmt_pkg::OFS_CR0;

		run = st.ctrl[cmt_pkg::CTRL_EN] & ~st.ctrl[cmt_pkg::CTRL_RST];
		step = run & src_tick;
		tick = step & (st.pc == st.pr);
		if (step)
			next_st.pc = tick ? '0 : st.pc + 32'h1;
		if (tick)
			next_st.tc = st.tc + 32'h1;

		// A match acts only on the counting tick, so a held count
		// cannot fire the same match over and over
		for (int i = 0; i < cmt_pkg::NCH; i++)
		begin
			if (tick && match_hit[i])
			begin
				if (st.mcr[i * cmt_pkg::MCR_STRIDE + cmt_pkg::MCR_RST])
				begin
					next_st.tc = '0;
				end
				if (st.mcr[i * cmt_pkg::MCR_STRIDE + cmt_pkg::MCR_STOP])
				begin
					next_st.ctrl[cmt_pkg::CTRL_EN] = 1'b0;
				end
				set_bits[i] = st.mcr[i * cmt_pkg::MCR_STRIDE
					+ cmt_pkg::MCR_INT];
				act = st.emr[cmt_pkg::EMR_ACT_LSB + 2 * i +: 2];
				case (act)
					cmt_pkg::ACT_LOW: next_st.emr[i] = 1'b0;
					cmt_pkg::ACT_HIGH: next_st.emr[i] = 1'b1;
					cmt_pkg::ACT_TOGGLE: next_st.emr[i] = ~st.emr[i];
					default: next_st.emr[i] = st.emr[i];
				endcase
			end
			if (cap_hit[i])
				next_st.cr[i] = st.tc;
			set_bits[cmt_pkg::ST_CAP_LSB + i] = cap_flag[i];
		end

		// Counter reset holds both counters at zero
		if (st.ctrl[cmt_pkg::CTRL_RST])
		begin
			next_st.tc = '0;
			next_st.pc = '0;
		end

		// ********************************************************
		// Register decode; a software write beats a counter update
		// ********************************************************
		if (paddr == cmt_pkg::OFS_STATUS)
		begin
			rdata = {24'h0, st.status};
		end
		else if (paddr == cmt_pkg::OFS_CLEAR)
		begin
			if (wr)
				clr_bits = pwdata[7:0];
		end
		else if (paddr == cmt_pkg::OFS_IEN)
		begin
			rdata = {24'h0, st.ien};
			if (wr)
				next_st.ien = pwdata[7:0];
		end
		else if (paddr == cmt_pkg::OFS_CTRL)
		begin
			rdata = {30'h0, st.ctrl};
			if (wr)
				next_st.ctrl = pwdata[1:0];
		end
		else if (paddr == cmt_pkg::OFS_TC)
		begin
			rdata = st.tc;
			if (wr)
				next_st.tc = pwdata;
		end
		else if (paddr == cmt_pkg::OFS_PR)
		begin
			rdata = st.pr;
			if (wr)
				next_st.pr = pwdata;
		end
		else if (paddr == cmt_pkg::OFS_PC)
		begin
			rdata = st.pc;
			if (wr)
				next_st.pc = pwdata;
		end
		else if (paddr == cmt_pkg::OFS_MCR)
		begin
			rdata = {20'h0, st.mcr};
			if (wr)
				next_st.mcr = pwdata[11:0];
		end
		else if (paddr >= cmt_pkg::OFS_MR0 && paddr < cmt_pkg::OFS_MR_END
			&& paddr[1:0] == 2'h0)
		begin
			rdata = st.mr[mofs[3:2]];
			if (wr)
				next_st.mr[mofs[3:2]] = pwdata;
		end
		else if (paddr == cmt_pkg::OFS_CCR)
		begin
			rdata = {20'h0, st.ccr};
			if (wr)
				next_st.ccr = pwdata[11:0];
		end
		else if (paddr >= cmt_pkg::OFS_CR0 && paddr < cmt_pkg::OFS_CR_END
			&& paddr[1:0] == 2'h0)
		begin
			rdata = st.cr[cofs[3:2]];
		end
		else if (paddr == cmt_pkg::OFS_EMR)
		begin
			rdata = {20'h0, st.emr};
			if (wr)
				next_st.emr = pwdata[11:0];
		end
		else if (paddr == cmt_pkg::OFS_CTCR)
		begin
			rdata = {28'h0, st.ctcr};
			// A two bit selector names one channel only
			if (wr)
				next_st.ctcr = pwdata[3:0];
		end
		else if (paddr == cmt_pkg::OFS_ROUTE)
		begin
			rdata = {20'h0, st.route};
			if (wr)
				next_st.route = pwdata[11:0];
		end
		else if (paddr == cmt_pkg::OFS_MOUT_EN)
		begin
			rdata = {24'h0, st.mout_en};
			if (wr)
				next_st.mout_en = pwdata[7:0];
		end
		else
		begin
			hit = 1'b0;
		end

		// ********************************************************
		// Flags, interrupt and pins
		// ********************************************************
		// A new event wins over a clear in the same cycle
		next_st.status = (st.status & ~clr_bits) | set_bits;
		next_st.irq = |(next_st.status & next_st.ien);
		for (int j = 0; j < cmt_pkg::NPIN; j++)
		begin
			next_st.match_pin[j] = next_st.mout_en[j]
				& next_st.emr[j % cmt_pkg::NCH];
		end

		// Answer one cycle into the access phase
		next_st.pready = acc;
		if (acc)
		begin
			// Read data holds until the next read answer
			if (!pwrite)
				next_st.prdata = rdata;
			next_st.pslverr = ~hit;
		end
		else if (st.pready)
		begin
			next_st.pslverr = 1'b0;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.route <= cmt_pkg::ROUTE_RST;
			st.mout_en <= cmt_pkg::MOUT_EN_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign match_pin = st.match_pin;
	assign irq = st.irq;

endmodule

// >>> bench/cmt_timer_assertions.sv
`timescale 1ns/1ps
module cmt_timer_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] capture_input_pin,
	input wire logic [7:0] match_pin,
	input wire logic irq
);
	// ********
	// Checks
	// ********
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic wr_ack = psel && penable && pready && pwrite;
	ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("answer not in second access cycle");
	ready_one_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_sel_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_err_a: assert property
		(pready && pslverr && !pwrite |-> prdata == 0)
		else $error("refused read not zero");
	prdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
		else $error("prdata moved outside read answer");
	irq_holds_a: assert property (irq && !wr_ack |=> irq)
		else $error("irq dropped without software write");
	irq_drop_a: assert property ($fell(irq) |-> $past(wr_ack))
		else $error("irq fell with no write before");
	cover property ($rose(irq));
	cover property (pready && pslverr);
	cover property ($changed(match_pin));
endmodule

// >>> bench/cmt_pin_model.sv
`timescale 1ns/1ps
module cmt_pin_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [3:0] n,
	input wire logic [1:0] hold,
	input wire logic [7:1] aux,
	output logic [7:0] pins,
	output logic busy
);
	// ********
	// Count source
	// ********
	logic [3:0] rem;
	logic [1:0] cnt;
	logic lvl;
	assign pins = {aux, lvl};
	assign busy = rem != 4'h0;
	// Idle low between bursts: the source does not free-run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rem <= 4'h0;
			cnt <= 2'h0;
			lvl <= 1'h0;
		end
		else if (start)
		begin
			rem <= n;
			cnt <= 2'h0;
			lvl <= 1'h0;
		end
		else if (busy)
		begin
			// Each level lasts hold+1 cycles, one at least
			cnt <= (cnt == hold) ? 2'h0 : cnt + 2'h1;
			if (cnt == hold)
			begin
				lvl <= ~lvl;
				if (lvl)
					rem <= rem - 4'h1;
			end
		end
	end
endmodule

// >>> bench/cmt_timer_tb.sv
`timescale 1ns/1ps
module cmt_timer_tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, pr;
	logic pready, pslverr, irq, busy;
	logic [7:0] match_pin, pins;
	logic start = 1'h0;
	logic [3:0] n = 4'h0;
	logic [1:0] hold = 2'h1;
	logic [6:0] aux = 7'h00;
	logic [44:0] expq[$];
	int n_fail = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h000118C6;
	always #20 pclk = ~pclk;
	cmt_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(pins), .match_pin(match_pin), .irq(irq));
	cmt_pin_model mdl_u (.pclk(pclk), .presetn(presetn), .start(start),
		.n(n), .hold(hold), .aux(aux), .pins(pins), .busy(busy));
	// ********
	// Helpers
	// ********
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic end_of_test;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_word(input logic [44:0] e, input logic [32:0] g);
		total_checks++;
		if (g !== e[32:0])
		begin
			$display("BAD reg %h exp %h got %h", e[44:33], e[32:0], g);
			n_fail++;
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			$display("BAD %s exp %b got %b", nm, e, g);
			n_fail++;
		end
	endtask
	// Idle cycle first, so psel is never driven twice at one edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'h1 && k < 20);
		if (pready !== 1'h1)
		begin
			chk_bit("pready", 1'h1, pready);
			end_of_test();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic e = 1'h0);
		expq.push_back({a, e, d});
		xfer(1'h0, a, 32'h0);
	endtask
	task automatic wait_sig(ref logic s, input logic v);
		int k;
		k = 0;
		while (s !== v && k < 300)
		begin
			@(posedge pclk);
			k++;
		end
		if (k >= 300)
		begin
			chk_bit("wait", v, s);
			end_of_test();
		end
	endtask
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'h1 && !pwrite)
			chk_word(expq.pop_front(), {pslverr, prdata});
	end
	// ********
	// Scenarios
	// ********
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		rd(cmt_pkg::OFS_ROUTE, 32'h249);
		rd(cmt_pkg::OFS_MOUT_EN, 32'h0F);
		rd(12'h054, 32'h0, 1'h1);
		pr = rnd() % 4;
		wr(cmt_pkg::OFS_PR, pr);
		wr(cmt_pkg::OFS_MR0, 32'h5);
		wr(cmt_pkg::OFS_MCR, 32'h7);
		wr(cmt_pkg::OFS_EMR, 32'h1B4);
		wr(cmt_pkg::OFS_IEN, 32'h1);
		wr(cmt_pkg::OFS_CTRL, 32'h1);
		wait_sig(irq, 1'h1);
		rd(cmt_pkg::OFS_TC, 32'h0);
		rd(cmt_pkg::OFS_CTRL, 32'h0);
		rd(cmt_pkg::OFS_STATUS, 32'h1);
		rd(cmt_pkg::OFS_EMR, 32'h1B3);
		chk_bit("match0", 1'h1, match_pin[0]);
		chk_bit("match1", 1'h1, match_pin[1]);
		chk_bit("match2", 1'h0, match_pin[2]);
		chk_bit("match4", 1'h0, match_pin[4]);
		wr(cmt_pkg::OFS_MOUT_EN, 32'h11);
		repeat (2) @(posedge pclk);
		chk_bit("match4", 1'h1, match_pin[4]);
		wr(cmt_pkg::OFS_IEN, 32'h0);
		@(posedge pclk);
		chk_bit("irq", 1'h0, irq);
		rd(cmt_pkg::OFS_STATUS, 32'h1);
		wr(cmt_pkg::OFS_IEN, 32'h1);
		@(posedge pclk);
		chk_bit("irq", 1'h1, irq);
		wr(cmt_pkg::OFS_CLEAR, 32'h1);
		@(posedge pclk);
		chk_bit("irq", 1'h0, irq);
		rd(cmt_pkg::OFS_STATUS, 32'h0);
		wr(cmt_pkg::OFS_TC, 32'h64);
		wr(cmt_pkg::OFS_CCR, 32'h168);
		wr(cmt_pkg::OFS_ROUTE, 32'h3C9);
		wr(cmt_pkg::OFS_IEN, 32'h70);
		aux <= 7'h01;
		wait_sig(irq, 1'h1);
		rd(cmt_pkg::OFS_CR0 + 12'h4, 32'h64);
		rd(cmt_pkg::OFS_STATUS, 32'h20);
		wr(cmt_pkg::OFS_CLEAR, 32'h20);
		wr(cmt_pkg::OFS_TC, 32'hC8);
		aux <= 7'h03;
		rd(cmt_pkg::OFS_STATUS, 32'h0);
		aux <= 7'h23;
		wait_sig(irq, 1'h1);
		rd(cmt_pkg::OFS_CR0 + 12'h8, 32'hC8);
		rd(cmt_pkg::OFS_STATUS, 32'h40);
		aux <= 7'h00;
		wr(cmt_pkg::OFS_CLEAR, 32'hFF);
		wr(cmt_pkg::OFS_MCR, 32'h0);
		wr(cmt_pkg::OFS_CTCR, 32'h1);
		wr(cmt_pkg::OFS_PR, 32'h0);
		wr(cmt_pkg::OFS_TC, 32'h0);
		wr(cmt_pkg::OFS_CCR, 32'h2D);
		wr(cmt_pkg::OFS_CTRL, 32'h1);
		n <= 4'(3 + rnd() % 8);
		hold <= 2'(1 + rnd() % 3);
		start <= 1'h1;
		@(posedge pclk);
		start <= 1'h0;
		aux <= 7'h01;
		@(posedge pclk);
		wait_sig(busy, 1'h0);
		repeat (3) @(posedge pclk);
		rd(cmt_pkg::OFS_TC, 32'(n));
		rd(cmt_pkg::OFS_STATUS, 32'h20);
		wr(cmt_pkg::OFS_CTCR, 32'h3);
		wr(cmt_pkg::OFS_TC, 32'h0);
		start <= 1'h1;
		@(posedge pclk);
		start <= 1'h0;
		@(posedge pclk);
		wait_sig(busy, 1'h0);
		repeat (3) @(posedge pclk);
		rd(cmt_pkg::OFS_TC, 32'(n) * 32'h2);
		wr(cmt_pkg::OFS_CTRL, 32'h3);
		rd(cmt_pkg::OFS_TC, 32'h0);
		repeat (2) @(posedge pclk);
		end_of_test();
	end
endmodule
bind cmt_timer cmt_timer_assertions chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.capture_input_pin(capture_input_pin), .match_pin(match_pin), .irq(irq));
